// *** pipe_ctl_consts.vh ***
// constants for the five-stage pipeline controller: class codes, option codes,
// latencies, exception codes; included by pipe_ctl.v by its bare name
`ifndef PIPE_CTL_CONSTS_VH
`define PIPE_CTL_CONSTS_VH

// ------------------------------------------------------------
// stage positions in the valid vector
// ------------------------------------------------------------
`define STG_F 0
`define STG_D 1
`define STG_E 2
`define STG_M 3
`define STG_W 4

// ------------------------------------------------------------
// instruction classes, delivered by the decoder for the D stage
// ------------------------------------------------------------
`define CLS_ALU    4'h0
`define CLS_BRANCH 4'h1
`define CLS_JUMP   4'h2
`define CLS_SYS    4'h3
`define CLS_TRAP   4'h4
`define CLS_UNIMP  4'h5
`define CLS_ICACHE 4'h6
`define CLS_SHIFT  4'h7
`define CLS_MUL    4'h8
`define CLS_DIV    4'h9
`define CLS_LDST   4'hA
`define CLS_CUSTOM 4'hB
`define CLS_RDCTL  4'hC

// ------------------------------------------------------------
// multiplier options
// ------------------------------------------------------------
`define MUL_NONE  2'h0
`define MUL_LE    2'h1
`define MUL_EMB32 2'h2
`define MUL_EMB16 2'h3

// ------------------------------------------------------------
// cycle counts
// ------------------------------------------------------------
`define CYC_ONE        7'h01
`define CYC_BR_TAKEN   7'h02
`define CYC_FLUSH      7'h04
`define CYC_SHIFT_EMB  7'h03
`define CYC_SHIFT_LE   7'h04
`define CYC_MUL_LE     7'h0B
`define CYC_MUL_EMB32  7'h03
`define CYC_MUL_EMB16  7'h05
`define CYC_DIV_MIN    7'h04
`define CYC_DIV_MAX    7'h42

// ------------------------------------------------------------
// exception codes, one-hot
// ------------------------------------------------------------
`define EXC_NONE  3'h0
`define EXC_IRQ   3'h1
`define EXC_TRAP  3'h2
`define EXC_UNIMP 3'h4

// ------------------------------------------------------------
// addresses
// ------------------------------------------------------------
`define RESET_ADDR 32'h00000000
`define EXC_ADDR   32'h00000020

`endif

// *** pipe_ctl.v ***
// five-stage pipeline controller: stage valid bits, stall, flush, static
// branch prediction, fetch address and per-instruction cycle accounting.
// assumes a decoder, an execute datapath and both bus masters on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctl_consts.vh"

module pipe_ctl #(
    parameter [1:0]  MUL_OPT    = `MUL_EMB32,
    parameter [31:0] RESET_ADDR = `RESET_ADDR,
    parameter [31:0] EXC_ADDR   = `EXC_ADDR
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // instruction master
    input  wire        imem_valid,
    output reg         imem_req_q,
    output reg  [31:0] imem_addr_q,
    // decode stage information
    input  wire [3:0]  d_class,
    input  wire        d_offset_neg,
    input  wire [31:0] d_target,
    // execute stage operand information
    input  wire [4:0]  e_shift_amt,
    input  wire [6:0]  e_div_cycles,
    // memory stage resolution
    input  wire        m_taken,
    input  wire [31:0] m_next_pc,
    input  wire        dm_done,
    input  wire        ci_stall,
    input  wire        irq_req,
    // status
    output reg  [4:0]  stage_valid_q,
    output reg         stall_q,
    output reg         flush_q,
    output reg  [31:0] redirect_addr_q,
    output reg         retire_q,
    output reg  [6:0]  retire_cycles_q,
    output reg  [2:0]  exc_q
);

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------

// nominal cost of an instruction once its class is known
function [6:0] base_cost;
    input [3:0] cls;
    input       pred;
    begin
        case (cls)
            `CLS_BRANCH: base_cost = pred ? `CYC_BR_TAKEN : `CYC_ONE;
            `CLS_JUMP:   base_cost = `CYC_FLUSH;
            `CLS_SYS,
            `CLS_TRAP,
            `CLS_UNIMP:  base_cost = `CYC_FLUSH;
            `CLS_ICACHE: base_cost = `CYC_FLUSH;
            default:     base_cost = `CYC_ONE;
        endcase
    end
endfunction

// does this class end in a pipeline flush
function flushes;
    input [3:0] cls;
    begin
        flushes = (cls == `CLS_JUMP) || (cls == `CLS_SYS) || (cls == `CLS_TRAP) ||
                  (cls == `CLS_UNIMP) || (cls == `CLS_ICACHE);
    end
endfunction

// does this class occupy the memory stage for more than its first cycle
function is_multi;
    input [3:0] cls;
    begin
        is_multi = (cls == `CLS_SHIFT) || (cls == `CLS_MUL) || (cls == `CLS_DIV);
    end
endfunction

// ------------------------------------------------------------
// stage state
// ------------------------------------------------------------
reg  [4:0]  v_q;
reg  [4:0]  v_d;
reg  [3:0]  e_cls_q;
reg  [3:0]  m_cls_q;
reg         e_pred_q;
reg         m_pred_q;
reg  [6:0]  m_cost_q;
reg  [6:0]  mc_q;
reg  [31:0] pc_q;

wire        stall;
wire        m_go;
wire        mispredict;
wire        irq_take;
wire        flush;
wire        pred_take;
wire [31:0] redirect;
wire [2:0]  exc_code;
wire [31:0] pc_next;
reg  [6:0]  e_lat;

// ------------------------------------------------------------
// stage map and limitations
// ------------------------------------------------------------
// e_cls_q and e_pred_q describe the instruction now in execute; they are
// captured from the decoder's view of decode as that instruction moves on.
// m_cls_q, m_pred_q and m_cost_q describe the instruction now in memory.
// mc_q counts the extra memory-stage cycles of a shift, multiply or divide;
// it only runs down while the stall holds, so a bus wait cannot eat it.
// bus and custom waits never load mc_q, they stall on their own inputs.
// the decoder must mark multiply as unimplemented when no multiplier exists,
// since the multiply latency table has no entry for that option.
// a divide duration outside its legal span is clamped, not refused.
// interrupts are taken only as a memory-stage instruction completes, so a
// long stall also delays the interrupt; this keeps retirement in order.
// a fetch word offered during a stall is dropped and fetched again, and one
// offered during a redirect is dropped; this costs a bubble but needs no buffer in front of decode.
// the class registers load even into empty stages; only the valid bits
// decide whether anything acts on them, which keeps the muxes small.

// ------------------------------------------------------------
// multi-cycle latency of the instruction leaving execute
// ------------------------------------------------------------

// shift and multiply latency depends on the multiplier option chosen at build time
always @* begin
    e_lat = base_cost(e_cls_q, e_pred_q);
    case (e_cls_q)
        `CLS_SHIFT: begin
            case (MUL_OPT)
                `MUL_NONE:  e_lat = (e_shift_amt == 5'h00) ? `CYC_ONE
                                  : {2'h0, e_shift_amt};
                `MUL_LE:    e_lat = `CYC_SHIFT_LE;
                default:    e_lat = `CYC_SHIFT_EMB;
            endcase
        end
        `CLS_MUL: begin
            case (MUL_OPT)
                `MUL_LE:    e_lat = `CYC_MUL_LE;
                `MUL_EMB16: e_lat = `CYC_MUL_EMB16;
                default:    e_lat = `CYC_MUL_EMB32;
            endcase
        end
        `CLS_DIV: begin
            if (e_div_cycles < `CYC_DIV_MIN) begin
                e_lat = `CYC_DIV_MIN;
            end else if (e_div_cycles > `CYC_DIV_MAX) begin
                e_lat = `CYC_DIV_MAX;
            end else begin
                e_lat = e_div_cycles;
            end
        end
        default: begin
            e_lat = base_cost(e_cls_q, e_pred_q);
        end
    endcase
end

// ------------------------------------------------------------
// stall and flush decisions
// ------------------------------------------------------------

// only memory-stage conditions feed the stall; fetch waits become bubbles instead
assign stall = v_q[`STG_M] & (
                 ((m_cls_q == `CLS_LDST) & ~dm_done) |
                 (mc_q != 7'h00) |
                 ((m_cls_q == `CLS_CUSTOM) & ci_stall));

assign m_go       = v_q[`STG_M] & ~stall;
assign mispredict = m_go & (m_cls_q == `CLS_BRANCH) & (m_taken != m_pred_q);
assign irq_take   = m_go & irq_req;
assign flush      = m_go & (flushes(m_cls_q) | mispredict | irq_take);

// branch predicted taken in decode redirects fetch and drops the F slot and the word arriving with it
assign pred_take  = v_q[`STG_D] & ~stall & ~flush &
                    (d_class == `CLS_BRANCH) & d_offset_neg;

// traps, unimplemented and interrupts go to the handler address
assign exc_code = ~m_go                      ? `EXC_NONE  :
                  irq_take                   ? `EXC_IRQ   :
                  (m_cls_q == `CLS_TRAP)     ? `EXC_TRAP  :
                  (m_cls_q == `CLS_UNIMP)    ? `EXC_UNIMP : `EXC_NONE;
assign redirect = (exc_code != `EXC_NONE) ? EXC_ADDR : m_next_pc;

// next fetch address for the copy on the output port; the pc register repeats the same choice
assign pc_next  = flush                  ? redirect                :
                  pred_take              ? d_target                :
                  (imem_valid & ~stall)  ? pc_q + 32'h00000004     : pc_q;

// ------------------------------------------------------------
// next valid vector
// ------------------------------------------------------------

// under a stall F..M hold as they are and W takes a bubble; no gap is closed
always @* begin
    v_d = v_q;
    if (stall) begin
        v_d[`STG_W] = 1'b0;
    end else begin
        v_d[`STG_W] = v_q[`STG_M];
        v_d[`STG_M] = v_q[`STG_E];
        v_d[`STG_E] = v_q[`STG_D];
        v_d[`STG_D] = v_q[`STG_F] & ~pred_take;
        v_d[`STG_F] = imem_valid & ~pred_take;
        if (flush) begin
            v_d[`STG_M] = 1'b0;
            v_d[`STG_E] = 1'b0;
            v_d[`STG_D] = 1'b0;
            v_d[`STG_F] = 1'b0;
        end
    end
end

// ------------------------------------------------------------
// stage registers
// ------------------------------------------------------------

// class and prediction ride along with each instruction
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        v_q      <= 5'h00;
        e_cls_q  <= `CLS_ALU;
        m_cls_q  <= `CLS_ALU;
        e_pred_q <= 1'b0;
        m_pred_q <= 1'b0;
        m_cost_q <= `CYC_ONE;
        mc_q     <= 7'h00;
    end else begin
        v_q <= v_d;
        if (stall) begin
            // a bus or custom wait leaves the counter at zero; never wrap it
            if (mc_q != 7'h00) begin
                mc_q <= mc_q - 7'h01;
            end
        end else begin
            e_cls_q  <= d_class;
            e_pred_q <= (d_class == `CLS_BRANCH) & d_offset_neg;
            m_cls_q  <= e_cls_q;
            m_pred_q <= e_pred_q;
            m_cost_q <= e_lat;
            // the first memory-stage cycle counts, so the wait is one less
            if (v_q[`STG_E] & ~flush & (e_lat != 7'h00) & is_multi(e_cls_q)) begin
                mc_q <= e_lat - 7'h01;
            end else begin
                mc_q <= 7'h00;
            end
        end
    end
end

// ------------------------------------------------------------
// fetch address
// ------------------------------------------------------------

// a word arriving during a stall is dropped and fetched again afterwards
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        pc_q       <= RESET_ADDR;
        imem_req_q <= 1'b0;
    end else begin
        imem_req_q <= 1'b1;
        if (flush) begin
            pc_q <= redirect;
        end else if (pred_take) begin
            pc_q <= d_target;
        end else if (imem_valid & ~stall) begin
            pc_q <= pc_q + 32'h00000004;
        end
    end
end

// ------------------------------------------------------------
// registered status outputs
// ------------------------------------------------------------

// outputs trail the internal decisions by one cycle so each leaves a flop
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        imem_addr_q     <= RESET_ADDR;
        stage_valid_q   <= 5'h00;
        stall_q         <= 1'b0;
        flush_q         <= 1'b0;
        redirect_addr_q <= RESET_ADDR;
        retire_q        <= 1'b0;
        retire_cycles_q <= 7'h00;
        exc_q           <= `EXC_NONE;
    end else begin
        imem_addr_q     <= pc_next;
        stage_valid_q   <= v_d;
        stall_q         <= stall;
        flush_q         <= flush;
        redirect_addr_q <= redirect;
        retire_q        <= m_go;
        retire_cycles_q <= mispredict ? `CYC_FLUSH : m_cost_q;
        exc_q           <= exc_code;
    end
end

endmodule

`default_nettype wire

// *** pipe_ctl_sva.sv ***
// assertions on the pipeline controller's ports
// assumes the controller's constants header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctl_consts.vh"
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module pipe_ctl_sva #(
    parameter [31:0] RESET_ADDR = `RESET_ADDR,
    parameter [31:0] EXC_ADDR   = `EXC_ADDR
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // status
    input wire logic [31:0] imem_addr_q,
    input wire logic [4:0]  stage_valid_q,
    input wire logic        stall_q,
    input wire logic        flush_q,
    input wire logic [31:0] redirect_addr_q,
    input wire logic        retire_q,
    input wire logic [6:0]  retire_cycles_q,
    input wire logic [2:0]  exc_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a flush leaves F..M empty with the flusher in W
    sequence s_cleared;
        flush_q && stage_valid_q[3:0] == 4'h0 && stage_valid_q[4];
    endsequence
    // the hole then walks down one stage a cycle, never skipped
    sequence s_hole;
        stage_valid_q[3:1] == 3'h0 ##1 stage_valid_q[3:2] == 2'h0 ##1 !stage_valid_q[3];
    endsequence
    AST_RESET_EMPTY: assert property ($rose(rst_n) |-> stage_valid_q == 5'h00
        && !stall_q && imem_addr_q == RESET_ADDR) else $error("pipe not empty after reset");
    AST_HOLE_WALK: assert property (s_cleared |=> s_hole)
        else $error("stages advanced out of order");
    AST_FLUSH_CLEAR: assert property (flush_q |-> s_cleared)
        else $error("flush left younger stages valid");
    AST_FLUSH_COST: assert property (flush_q && exc_q == 3'h0 |-> retire_q
        && retire_cycles_q == 7'h04) else $error("flush cost not four");
    AST_EXC_VECTOR: assert property (retire_q && exc_q != 3'h0 |-> flush_q
        && redirect_addr_q == EXC_ADDR) else $error("exception not vectored");
    AST_EXC_ONEHOT: assert property (retire_q |-> $onehot0(exc_q))
        else $error("exception code not one-hot");
    AST_STALL_FREEZE: assert property (stall_q |-> stage_valid_q[3:0] ==
        $past(stage_valid_q[3:0]) && $stable(imem_addr_q)) else $error("stall did not freeze");
    AST_NO_CATCHUP: assert property (stall_q |-> !stage_valid_q[4])
        else $error("stall did not leave a bubble");
    AST_M_ONLY: assert property (stall_q |-> $past(stage_valid_q[3]))
        else $error("stall without memory stage");
    AST_RETIRE_ONE: assert property (retire_q |-> !stall_q && stage_valid_q[4])
        else $error("retire during stall");
endmodule

bind pipe_ctl pipe_ctl_sva #(.RESET_ADDR(RESET_ADDR), .EXC_ADDR(EXC_ADDR)) u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .imem_addr_q(imem_addr_q),
    .stage_valid_q(stage_valid_q), .stall_q(stall_q), .flush_q(flush_q),
    .redirect_addr_q(redirect_addr_q), .retire_q(retire_q),
    .retire_cycles_q(retire_cycles_q), .exc_q(exc_q));
`default_nettype wire

// *** bus_far_model.sv ***
// far side: instruction master answers, data transfer and custom unit waits
// assumes the controller's fetch request and memory-stage valid on core_clk
`timescale 1ns/1ps
`default_nettype none
module bus_far_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // controller side
    input  wire logic       imem_req_q,
    input  wire logic       m_valid,
    // behaviour: slow fetch, wait cycles per memory-stage op
    input  wire logic       slow,
    input  wire logic [3:0] dly,
    // answers
    output var logic        imem_valid,
    output var logic        dm_done,
    output var logic        ci_stall
);
    logic [3:0] cnt_q;
    logic       tog_q;
    // answers change on the falling edge so they are settled at the sample
    always @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {imem_valid, dm_done, ci_stall, tog_q, cnt_q} <= 8'h00;
        end else begin
            tog_q      <= ~tog_q;
            imem_valid <= imem_req_q & (~slow | tog_q); // slow fetch gives bubbles
            if (m_valid && cnt_q == dly) begin
                dm_done  <= 1'b1;
                ci_stall <= 1'b0;
                cnt_q    <= 4'h0;
            end else begin
                dm_done  <= 1'b0;
                ci_stall <= m_valid;
                cnt_q    <= m_valid ? cnt_q + 4'h1 : 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the pipeline controller
// assumes the constants header, the far-side model and the checker
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctl_consts.vh"
module testbench;
    localparam [31:0] TGT = 32'h00000800; // branch target, far from the fetch run
    localparam [31:0] NXT = 32'h00000400;
    logic        core_clk, rst_n, d_offset_neg, m_taken, irq_req, slow;
    logic [3:0]  d_class, dly;
    logic [6:0]  e_div_cycles;
    wire         imem_valid, dm_done, ci_stall, imem_req_q, stall_q, flush_q, retire_q;
    wire  [31:0] imem_addr_q, redirect_addr_q;
    wire  [4:0]  stage_valid_q;
    wire  [6:0]  retire_cycles_q;
    wire  [2:0]  exc_q;
    int          failures, num_checks, cyc;
    pipe_ctl #(.MUL_OPT(`MUL_EMB32)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .imem_valid(imem_valid), .imem_req_q(imem_req_q), .imem_addr_q(imem_addr_q),
        .d_class(d_class), .d_offset_neg(d_offset_neg), .d_target(TGT),
        .e_shift_amt(5'h1F), .e_div_cycles(e_div_cycles), .m_taken(m_taken),
        .m_next_pc(NXT), .dm_done(dm_done), .ci_stall(ci_stall), .irq_req(irq_req),
        .stage_valid_q(stage_valid_q), .stall_q(stall_q), .flush_q(flush_q),
        .redirect_addr_q(redirect_addr_q), .retire_q(retire_q),
        .retire_cycles_q(retire_cycles_q), .exc_q(exc_q));
    bus_far_model i_far (.core_clk(core_clk), .rst_n(rst_n), .imem_req_q(imem_req_q),
        .m_valid(stage_valid_q[3]), .slow(slow), .dly(dly), .imem_valid(imem_valid),
        .dm_done(dm_done), .ci_stall(ci_stall));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // reset, stream one class, judge the first retire
    task automatic run(input [3:0] cls, input neg, tk, irq, input [3:0] dl,
                       input [6:0] div, ecyc, input int est, input [2:0] eexc, input ef);
        int   st = 0;
        int   n = 0;
        logic seen = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b0;
        {d_class, d_offset_neg, m_taken, irq_req, dly, e_div_cycles, slow} =
            {cls, neg, tk, irq, dl, div, cls[0]};
        @(negedge core_clk);
        chk("valid_at_reset", 32'h0, {27'h0, stage_valid_q});
        chk("addr_at_reset", `RESET_ADDR, imem_addr_q);
        chk("req_at_reset", 32'h0, {31'h0, imem_req_q});
        rst_n = 1'b1;
        while (n < 300) begin
            @(posedge core_clk);
            #1;
            if (retire_q === 1'b1) break;
            st += (stall_q === 1'b1);
            seen |= (imem_addr_q === TGT);
            n++;
        end
        chk("retired", 32'h1, {31'h0, retire_q});
        chk("fetch_req", 32'h1, {31'h0, imem_req_q});
        chk("cycles", {25'h0, ecyc}, {25'h0, retire_cycles_q});
        chk("stall_cycles", est, st);
        chk("flush", {31'h0, ef}, {31'h0, flush_q});
        if (ef) chk("redirect", (eexc != 3'h0) ? `EXC_ADDR : NXT, redirect_addr_q);
        chk("exception", {29'h0, eexc}, {29'h0, exc_q});
        chk("predicted", {31'h0, cls == `CLS_BRANCH && neg}, {31'h0, seen});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_single;
        run(`CLS_ALU, 0, 0, 0, 0, 7'h04, 7'h01, 0, 3'h0, 0);
        run(`CLS_RDCTL, 0, 0, 0, 0, 7'h04, 7'h01, 0, 3'h0, 0);
        run(`CLS_CUSTOM, 0, 0, 0, 0, 7'h04, 7'h01, 0, 3'h0, 0);
        run(`CLS_LDST, 0, 0, 0, 0, 7'h04, 7'h01, 0, 3'h0, 0);
        $display("single-cycle classes done");
    endtask
    task automatic t_branch;
        run(`CLS_BRANCH, 1, 1, 0, 0, 7'h04, 7'h02, 0, 3'h0, 0);
        run(`CLS_BRANCH, 0, 0, 0, 0, 7'h04, 7'h01, 0, 3'h0, 0);
        run(`CLS_BRANCH, 1, 0, 0, 0, 7'h04, 7'h04, 0, 3'h0, 1);
        run(`CLS_BRANCH, 0, 1, 0, 0, 7'h04, 7'h04, 0, 3'h0, 1);
        $display("branch prediction done");
    endtask
    task automatic t_flush;
        run(`CLS_JUMP, 0, 0, 0, 0, 7'h04, 7'h04, 0, 3'h0, 1);
        run(`CLS_SYS, 0, 0, 0, 0, 7'h04, 7'h04, 0, 3'h0, 1);
        run(`CLS_ICACHE, 0, 0, 0, 0, 7'h04, 7'h04, 0, 3'h0, 1);
        run(`CLS_TRAP, 0, 0, 0, 0, 7'h04, 7'h04, 0, 3'h2, 1);
        run(`CLS_UNIMP, 0, 0, 0, 0, 7'h04, 7'h04, 0, 3'h4, 1);
        run(`CLS_JUMP, 0, 0, 1, 0, 7'h04, 7'h04, 0, 3'h1, 1);
        $display("flushing classes done");
    endtask
    task automatic t_multi;
        run(`CLS_SHIFT, 0, 0, 0, 0, 7'h04, 7'h03, 2, 3'h0, 0);
        run(`CLS_MUL, 0, 0, 0, 0, 7'h04, 7'h03, 2, 3'h0, 0);
        run(`CLS_DIV, 0, 0, 0, 0, 7'h04, 7'h04, 3, 3'h0, 0);
        run(`CLS_DIV, 0, 0, 0, 0, 7'h42, 7'h42, 65, 3'h0, 0);
        $display("multi-cycle classes done");
    endtask
    task automatic t_waits;
        run(`CLS_LDST, 0, 0, 0, 3, 7'h04, 7'h01, 3, 3'h0, 0);
        run(`CLS_CUSTOM, 0, 0, 0, 2, 7'h04, 7'h01, 2, 3'h0, 0);
        $display("bus and custom waits done");
    endtask
    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // the whole run needs under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        {rst_n, d_offset_neg, m_taken, irq_req, slow, d_class, dly} = 13'h0000;
        e_div_cycles = 7'h04;
        repeat (2) @(negedge core_clk);
        t_single();
        t_branch();
        t_flush();
        t_multi();
        t_waits();
        stop_test();
    end
endmodule
`default_nettype wire
